// >>> design/hpdic_pkg.sv
package hpdic_pkg;

  // Host side register offsets on the three address pins.
  localparam logic [2:0] HPDIC_OFS_CONTROL = 3'h0;
  localparam logic [2:0] HPDIC_OFS_VECTOR = 3'h1;
  localparam logic [2:0] HPDIC_OFS_STATUS = 3'h2;
  localparam logic [2:0] HPDIC_OFS_IRQ_VECTOR = 3'h3;
  localparam logic [2:0] HPDIC_OFS_SPARE = 3'h4;

  // Byte register index inside the data group; address bit 2 is set.
  localparam logic [1:0] HPDIC_BYTE_HIGH = 2'h1;
  localparam logic [1:0] HPDIC_BYTE_MID = 2'h2;
  localparam logic [1:0] HPDIC_BYTE_LOW = 2'h3;

  // Transfer mode field encodings.
  localparam logic [1:0] HPDIC_MODE_IRQ = 2'h0;
  localparam logic [1:0] HPDIC_MODE_DMA24 = 2'h1;
  localparam logic [1:0] HPDIC_MODE_DMA16 = 2'h2;
  localparam logic [1:0] HPDIC_MODE_DMA8 = 2'h3;

  // Field positions of the interrupt control register.
  localparam int HPDIC_CTRL_RX_EN = 0;
  localparam int HPDIC_CTRL_TX_EN = 1;
  localparam int HPDIC_CTRL_MODE_LO = 5;
  localparam int HPDIC_CTRL_MODE_HI = 6;
  localparam int HPDIC_CTRL_INIT = 7;

  // Field positions of the command vector register.
  localparam int HPDIC_VEC_LSB = 0;
  localparam int HPDIC_VEC_MSB = 5;
  localparam int HPDIC_VEC_CMD_REQ = 7;

  // Reset values.
  localparam logic [5:0] HPDIC_VECTOR_RST = 6'h17;
  localparam logic [7:0] HPDIC_IRQ_VECTOR_RST = 8'h0f;

  // Core word and buffer sizes.
  localparam int HPDIC_WORD_W = 24;
  localparam int HPDIC_FIFO_DEPTH = 32;

  // Host pins sampled together through one synchroniser.
  typedef struct packed {
    logic cs_n;
    logic rw;
    logic strobe_n;
    logic ack_n;
    logic [2:0] addr;
    logic [7:0] data;
  } hpdic_pins_t;

  // Idle level of the pins: selects, strobe and acknowledge high.
  localparam logic [14:0] HPDIC_PINS_IDLE = 15'h5800;

endpackage

// >>> design/hpdic_sync.sv
`timescale 1ns/1ps
module hpdic_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] q_r;

  // Two flops; only the second stage is visible to the outside.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1_r <= RESET_VAL;
      q_r <= RESET_VAL;
    end else begin
      stage1_r <= d;
      q_r <= stage1_r;
    end
  end

  assign q = q_r;

endmodule // hpdic_sync

// >>> design/hpdic_fifo.sv
`timescale 1ns/1ps
module hpdic_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Explicit wrap keeps non power of two depths correct.
  always_ff @(posedge sys_clk) begin
    if (rst || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // hpdic_fifo

// >>> design/hpdic_top.sv
`timescale 1ns/1ps
// How it works
// RULE_01: Mode field 00 is interrupt mode; 01, 10, 11 are 24-, 16-, 8-bit DMA.
// RULE_02: Interrupt mode: request enables gate request pin; acknowledge returns vector.
// RULE_03: DMA mode: request pin asks for transfers, enables pick direction.
// RULE_04: DMA acknowledge drives selected byte out, or captures bus into it.
// RULE_05: During DMA a two-bit counter replaces the two low address bits.
// RULE_06: During DMA the top register address bit is forced to one.
// RULE_07: Each DMA byte advances the counter; at low byte it reloads mode.
// RULE_08: Every reset kind and stop clear the mode field to interrupt mode.
// RULE_09: Initialize bit runs the command then clears itself; resets clear it.
// RULE_10: Initialize loads the counter from the mode field.
// RULE_11: Initialize clears channel flags per enables; both in DMA undefined.
// RULE_12: A mode change alone leaves the counter untouched.
// RULE_13: Host sets initialize after every mode change.
// RULE_14: Initialize waits until a DMA transfer in progress has finished.
// RULE_15: Six-bit command vector; routine start is twice the vector.
// RULE_16: Every reset kind and stop load the command vector with 17 hex.
// RULE_17: Host never issues a command with vector zero.
// RULE_18: Command request bit and vector are taken in one write.
// RULE_19: Commands work apart from data paths and transfer mode.
// RULE_20: Host sets command request; core acknowledge clears; host may cancel.
// RULE_21: DMA receive enable means core to host, transmit enable host to core.
// RULE_22: Counter 01, 10, 11 select high, middle and low byte registers.
module hpdic_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic indiv_reset,
  input wire logic stop_mode,
  input wire logic host_cs_n,
  input wire logic host_rw,
  input wire logic host_strobe_n,
  input wire logic host_addr_2,
  input wire logic host_addr_1,
  input wire logic host_addr_0,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic host_request_n,
  input wire logic host_acknowledge_n,
  output logic core_rx_valid,
  input wire logic core_rx_ready,
  output logic [23:0] core_rx_data,
  input wire logic core_tx_valid,
  output logic core_tx_ready,
  input wire logic [23:0] core_tx_data,
  output logic core_receive_full,
  output logic core_transmit_empty,
  output logic cmd_pending,
  output logic [6:0] cmd_vector_addr,
  input wire logic cmd_ack,
  output logic dma_enabled
);

  typedef enum logic {HPDIC_DMA_IDLE, HPDIC_DMA_ACTIVE} hpdic_dma_t;

  hpdic_pkg::hpdic_pins_t pins_raw;
  hpdic_pkg::hpdic_pins_t pins;
  hpdic_dma_t dma_state_r;
  hpdic_dma_t dma_state_nxt;
  logic clr;
  logic rx_en_r;
  logic tx_en_r;
  logic [1:0] mode_r;
  logic init_r;
  logic [5:0] vector_r;
  logic command_request_r;
  logic [7:0] irq_vector_r;
  logic [1:0] cnt_r;
  logic [7:0] rx_byte_r [1:3];
  logic [7:0] tx_byte_r [1:3];
  logic [23:0] core_word_r;
  logic receive_full_r;
  logic transmit_empty_r;
  logic core_tx_empty_r;
  logic acc_prev_r;
  logic [2:0] lat_addr_r;
  logic [7:0] lat_data_r;
  logic lat_rw_r;
  logic [7:0] data_out_r;
  logic oe_r;
  logic acc;
  logic host_wr;
  logic host_rd_end;
  logic host_rd;
  logic ack_act;
  logic dma_on;
  logic dir_rx;
  logic dir_tx;
  logic dma_busy;
  logic dma_end;
  logic init_exec;
  logic req;
  logic irq_ack;
  logic [2:0] eff_addr;
  logic [7:0] read_word [0:7];
  logic [7:0] ctrl_rd;
  logic [7:0] status_rd;
  logic wr_ctrl;
  logic wr_vector;
  logic wr_irq_vector;
  logic tx_wr_en;
  logic [1:0] tx_sel;
  logic tx_low_done;
  logic rx_low_done;
  logic fifo_in_ready;
  logic fifo_push;
  logic move;
  logic core_accept;
  logic fifo_flush;

  // Every host pin is asynchronous, so the whole group is synchronised.
  assign pins_raw = '{cs_n: host_cs_n, rw: host_rw,
                      strobe_n: host_strobe_n, ack_n: host_acknowledge_n,
                      addr: {host_addr_2, host_addr_1, host_addr_0},
                      data: host_data_in};

  hpdic_sync #(
    .WIDTH(15),
    .RESET_VAL(hpdic_pkg::HPDIC_PINS_IDLE)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(pins_raw),
    .q(pins)
  );

  // All four clear sources act alike on mode, command and flag state; the interrupt vector, latches and byte registers differ.
  assign clr = rst || soft_reset || indiv_reset || stop_mode; // RULE_08

  // Host register strobes; a write lands when the strobe ends.
  assign acc = !pins.cs_n && !pins.strobe_n;
  assign host_wr = acc_prev_r && !acc && !lat_rw_r;
  assign host_rd_end = acc_prev_r && !acc && lat_rw_r;
  assign host_rd = acc && pins.rw && !dma_busy;
  assign wr_ctrl = host_wr && (lat_addr_r == hpdic_pkg::HPDIC_OFS_CONTROL);
  assign wr_vector = host_wr && (lat_addr_r == hpdic_pkg::HPDIC_OFS_VECTOR);
  assign wr_irq_vector = host_wr &&
                         (lat_addr_r == hpdic_pkg::HPDIC_OFS_IRQ_VECTOR);

  // Mode decode, transfer direction and request pin.
  assign dma_on = (mode_r != hpdic_pkg::HPDIC_MODE_IRQ); // RULE_01
  assign dir_rx = dma_on && rx_en_r && !tx_en_r; // RULE_21
  assign dir_tx = dma_on && tx_en_r && !rx_en_r; // RULE_03
  assign req = (rx_en_r && receive_full_r) ||
               (tx_en_r && transmit_empty_r); // RULE_02
  assign host_request_n = !req;
  assign ack_act = !pins.ack_n;
  assign irq_ack = !dma_on && ack_act && req; // RULE_02
  assign dma_enabled = dma_on;

  // A byte transfer lasts while acknowledge is held in a DMA mode.
  always_comb begin
    dma_state_nxt = dma_state_r;
    case (dma_state_r)
      HPDIC_DMA_IDLE: begin
        if (dma_on && ack_act) begin
          dma_state_nxt = HPDIC_DMA_ACTIVE; // RULE_03
        end
      end
      HPDIC_DMA_ACTIVE: begin
        if (!ack_act) begin
          dma_state_nxt = HPDIC_DMA_IDLE;
        end
      end
      default: dma_state_nxt = HPDIC_DMA_IDLE;
    endcase
  end

  assign dma_busy = (dma_state_r == HPDIC_DMA_ACTIVE);
  assign dma_end = dma_busy && !ack_act;
  assign eff_addr = dma_busy ? {1'b1, cnt_r} : pins.addr; // RULE_05 RULE_06

  // Initialize is held off while a byte transfer is under way.
  assign init_exec = init_r && !dma_busy; // RULE_14

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      dma_state_r <= HPDIC_DMA_IDLE;
    end else begin
      dma_state_r <= dma_state_nxt;
    end
  end

  // Latch the access while the strobe or acknowledge is active.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_prev_r <= 1'b0;
      lat_addr_r <= 3'h0;
      lat_rw_r <= 1'b1;
      lat_data_r <= 8'h00;
    end else begin
      acc_prev_r <= acc;
      if (acc) begin
        lat_addr_r <= pins.addr;
        lat_rw_r <= pins.rw;
      end
      if (acc || dma_busy) begin
        lat_data_r <= pins.data;
      end
    end
  end

  // Control register; a pending initialize survives until it runs.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
      mode_r <= hpdic_pkg::HPDIC_MODE_IRQ; // RULE_08
      init_r <= 1'b0; // RULE_09
    end else if (wr_ctrl) begin
      rx_en_r <= lat_data_r[hpdic_pkg::HPDIC_CTRL_RX_EN];
      tx_en_r <= lat_data_r[hpdic_pkg::HPDIC_CTRL_TX_EN];
      mode_r <= {lat_data_r[hpdic_pkg::HPDIC_CTRL_MODE_HI],
                 lat_data_r[hpdic_pkg::HPDIC_CTRL_MODE_LO]};
      init_r <= lat_data_r[hpdic_pkg::HPDIC_CTRL_INIT] ||
                (init_r && !init_exec);
    end else if (init_exec) begin
      init_r <= 1'b0; // RULE_09
    end
  end

  // Command vector: one write carries both fields, set beats acknowledge.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      vector_r <= hpdic_pkg::HPDIC_VECTOR_RST; // RULE_16
      command_request_r <= 1'b0;
    end else if (wr_vector) begin
      vector_r <= lat_data_r[hpdic_pkg::HPDIC_VEC_MSB:
                             hpdic_pkg::HPDIC_VEC_LSB]; // RULE_18
      command_request_r <= lat_data_r[hpdic_pkg::HPDIC_VEC_CMD_REQ]; // RULE_20
    end else if (cmd_ack) begin
      command_request_r <= 1'b0; // RULE_20
    end
  end

  // Command outputs ignore mode and data flags entirely.
  assign cmd_pending = command_request_r; // RULE_19
  assign cmd_vector_addr = {vector_r, 1'b0}; // RULE_15

  // The vector returned on an interrupt acknowledge; only full resets.
  always_ff @(posedge sys_clk) begin
    if (rst || soft_reset) begin
      irq_vector_r <= hpdic_pkg::HPDIC_IRQ_VECTOR_RST;
    end else if (wr_irq_vector) begin
      irq_vector_r <= lat_data_r;
    end
  end

  // Counter: initialize presets, each byte steps, low byte wraps.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      cnt_r <= hpdic_pkg::HPDIC_MODE_IRQ;
    end else if (init_exec) begin
      cnt_r <= mode_r; // RULE_10
    end else if (dma_end) begin
      if (cnt_r == hpdic_pkg::HPDIC_BYTE_LOW) begin
        cnt_r <= mode_r; // RULE_07
      end else begin
        cnt_r <= cnt_r + 2'h1; // RULE_07
      end
    end
    // A mode write alone never touches the counter.
  end // RULE_12

  // Byte selects; DMA writes take the counter, host writes the address.
  assign tx_wr_en = (dma_end && dir_tx) ||
                    (host_wr && lat_addr_r[2] && (lat_addr_r[1:0] != 2'h0));
  assign tx_sel = dma_end ? cnt_r : lat_addr_r[1:0]; // RULE_04
  assign tx_low_done = tx_wr_en && (tx_sel == hpdic_pkg::HPDIC_BYTE_LOW);
  assign rx_low_done = (dma_end && dir_rx &&
                        (cnt_r == hpdic_pkg::HPDIC_BYTE_LOW)) ||
                       (host_rd_end && (lat_addr_r == {1'b1,
                        hpdic_pkg::HPDIC_BYTE_LOW}));

  // Word moves: core word to receive bytes, transmit bytes to buffer.
  assign move = !receive_full_r && !core_tx_empty_r && !init_exec;
  assign core_accept = core_tx_valid && core_tx_empty_r;
  assign fifo_push = !transmit_empty_r && fifo_in_ready;
  assign fifo_flush = init_exec && tx_en_r; // RULE_11

  // Index 1 is the high byte and index 3 the low byte of a word.
  genvar gi;
  generate
    for (gi = 1; gi <= 3; gi++) begin : g_byte
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          tx_byte_r[gi] <= 8'h00;
          rx_byte_r[gi] <= 8'h00;
        end else begin
          if (tx_wr_en && (tx_sel == 2'(gi))) begin
            tx_byte_r[gi] <= lat_data_r; // RULE_04
          end
          if (move) begin
            rx_byte_r[gi] <= core_word_r[8*(3-gi) +: 8]; // RULE_22
          end
        end
      end
      assign read_word[4+gi] = rx_byte_r[gi]; // RULE_22
    end
  endgenerate

  // Channel flags; a hardware set always wins over a clear.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      receive_full_r <= 1'b0;
      transmit_empty_r <= 1'b1;
    end else begin
      if (move) begin
        receive_full_r <= 1'b1;
      end else if (rx_low_done || (init_exec && rx_en_r)) begin
        receive_full_r <= 1'b0; // RULE_11
      end
      if (fifo_push || (init_exec && tx_en_r)) begin
        transmit_empty_r <= 1'b1; // RULE_11
      end else if (tx_low_done) begin
        transmit_empty_r <= 1'b0;
      end
    end
  end

  // Core transmit stage; a word held when init runs with receive enabled is dropped.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      core_tx_empty_r <= 1'b1;
      core_word_r <= 24'h000000;
    end else begin
      if (core_accept) begin
        core_tx_empty_r <= 1'b0;
        core_word_r <= core_tx_data;
      end else if (move || (init_exec && rx_en_r)) begin
        core_tx_empty_r <= 1'b1; // RULE_11
      end
    end
  end

  assign core_tx_ready = core_tx_empty_r;
  assign core_transmit_empty = core_tx_empty_r;

  // Host to core words queue here; a slow core stalls the host bytes.
  hpdic_fifo #(
    .WIDTH(hpdic_pkg::HPDIC_WORD_W),
    .DEPTH(hpdic_pkg::HPDIC_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(clr),
    .flush(fifo_flush),
    .in_valid(!transmit_empty_r),
    .in_ready(fifo_in_ready),
    .in_data({tx_byte_r[1], tx_byte_r[2], tx_byte_r[3]}),
    .out_valid(core_rx_valid),
    .out_ready(core_rx_ready),
    .out_data(core_rx_data)
  );

  assign core_receive_full = core_rx_valid;

  // Read values of the host register map.
  assign ctrl_rd = {init_r, mode_r, 3'h0, tx_en_r, rx_en_r};
  assign status_rd = {req, dma_on, 3'h0,
                      transmit_empty_r && !core_rx_valid,
                      transmit_empty_r, receive_full_r};
  assign read_word[0] = ctrl_rd;
  assign read_word[1] = {command_request_r, 1'b0, vector_r};
  assign read_word[2] = status_rd;
  assign read_word[3] = irq_vector_r;
  assign read_word[4] = 8'h00;

  // Data pins are registered; the vector answer beats a register read.
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      data_out_r <= 8'h00;
      oe_r <= 1'b0;
    end else begin
      data_out_r <= irq_ack ? irq_vector_r : read_word[eff_addr]; // RULE_04
      oe_r <= irq_ack || host_rd || (dma_busy && dir_rx);
    end
  end

  assign host_data_out = data_out_r;
  assign host_data_oe = oe_r;

  default clocking hpdic_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  mode_reset_a: // RULE_08
    assert property (clr |=> mode_r == hpdic_pkg::HPDIC_MODE_IRQ && !init_r)
    else $error("mode or init not cleared by reset");

  vector_reset_a: // RULE_16
    assert property (clr |=> vector_r == hpdic_pkg::HPDIC_VECTOR_RST)
    else $error("command vector not preset");

  init_preset_a: // RULE_10
    assert property (init_exec && !clr |=> cnt_r == $past(mode_r))
    else $error("initialize did not load the counter");

  init_clear_a: // RULE_09
    assert property (init_exec && !clr && !wr_ctrl |=> !init_r)
    else $error("initialize bit not self cleared");

  init_defer_a: // RULE_14
    assert property (init_r && dma_busy && !clr |=> init_r)
    else $error("initialize ran during a transfer");

  counter_wrap_a: // RULE_07
    assert property (dma_end && !clr && cnt_r == hpdic_pkg::HPDIC_BYTE_LOW
                     |=> cnt_r == $past(mode_r))
    else $error("counter did not reload at low byte");

  counter_step_a: // RULE_07
    assert property (dma_end && !clr && cnt_r != hpdic_pkg::HPDIC_BYTE_LOW
                     |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("counter did not advance");

  dma_read_a: // RULE_04
    assert property (dma_busy && dir_rx && !clr ##1 !clr
                     |-> host_data_oe && host_data_out ==
                         $past(read_word[{1'b1, cnt_r}]))
    else $error("DMA byte not driven");

  irq_vector_a: // RULE_02
    assert property (irq_ack && !clr |=> host_data_oe &&
                     host_data_out == $past(irq_vector_r))
    else $error("vector not returned on acknowledge");

  init_flags_a: // RULE_11
    assert property (init_exec && rx_en_r && !clr && !core_accept
                     |=> !receive_full_r && core_tx_empty_r)
    else $error("initialize did not reset receive channel");

  cmd_write_a: // RULE_18
    assert property (wr_vector && !clr |=> command_request_r ==
                     $past(lat_data_r[7]) && vector_r == $past(lat_data_r[5:0]))
    else $error("command write not taken whole");

  cmd_ack_a: // RULE_20
    assert property (cmd_ack && !wr_vector && !clr |=> !cmd_pending)
    else $error("command acknowledge did not clear request");

endmodule // hpdic_top

// >>> sim/hpdic_host.sv
`timescale 1ns/1ps
// Host processor and its DMA controller, seen from the port pins.
module hpdic_host (
  input wire logic sys_clk,
  input wire logic dev_oe,
  input wire logic [7:0] dev_data,
  output logic cs_n,
  output logic rw,
  output logic strobe_n,
  output logic ack_n,
  output logic [2:0] addr,
  output logic [7:0] bus
);
  logic drv;
  logic [7:0] wdat;
  logic [7:0] last;
  // A released bus shows the inverse of its last level, never a stale copy.
  assign bus = dev_oe ? dev_data : (drv ? wdat : ~last);
  // Track the last driven level of the bus.
  always @(posedge sys_clk) begin
    if (dev_oe || drv) begin
      last <= bus;
    end
  end
  // Pins idle high from time zero.
  initial begin
    {cs_n, rw, strobe_n, ack_n} = 4'hf;
    addr = 3'h0;
    {drv, wdat, last} = 17'h0;
  end
  // One register access or one acknowledged byte. Pins are held five
  // edges because the port only sees them after its synchroniser.
  task automatic xfer(input logic dma, input logic [2:0] a,
    input logic wr, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    cs_n <= dma;
    strobe_n <= dma;
    ack_n <= ~dma;
    rw <= ~wr;
    addr <= dma ? 3'h0 : a;
    drv <= wr;
    wdat <= d;
    repeat (5) @(posedge sys_clk);
    q = bus;
    {cs_n, strobe_n, ack_n, rw, drv} <= 5'h1e;
    repeat (5) @(posedge sys_clk);
  endtask
endmodule // hpdic_host

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); \
  end \
end
// Self-checking bench for the host port control block.
module tb_top;
  logic sys_clk, rst, soft_reset, indiv_reset, stop_mode;
  logic cs_n, rw, strobe_n, ack_n, oe, req_n;
  logic [2:0] addr;
  logic [7:0] bus, dout;
  logic rx_valid, rx_ready, tx_valid, tx_ready, rxf, txe;
  logic [23:0] rx_data, tx_data;
  logic pending, cmd_ack, dma_en;
  logic [6:0] vaddr;
  int fail_count, tests_run;

  hpdic_host hpdic_host_i (.sys_clk(sys_clk), .dev_oe(oe),
    .dev_data(dout), .cs_n(cs_n), .rw(rw), .strobe_n(strobe_n),
    .ack_n(ack_n), .addr(addr), .bus(bus));
  hpdic_top hpdic_top_i (.sys_clk(sys_clk), .rst(rst),
    .soft_reset(soft_reset), .indiv_reset(indiv_reset),
    .stop_mode(stop_mode), .host_cs_n(cs_n), .host_rw(rw),
    .host_strobe_n(strobe_n), .host_addr_2(addr[2]),
    .host_addr_1(addr[1]), .host_addr_0(addr[0]),
    .host_data_in(bus), .host_data_out(dout), .host_data_oe(oe),
    .host_request_n(req_n), .host_acknowledge_n(ack_n),
    .core_rx_valid(rx_valid), .core_rx_ready(rx_ready),
    .core_rx_data(rx_data), .core_tx_valid(tx_valid),
    .core_tx_ready(tx_ready), .core_tx_data(tx_data),
    .core_receive_full(rxf), .core_transmit_empty(txe),
    .cmd_pending(pending), .cmd_vector_addr(vaddr),
    .cmd_ack(cmd_ack), .dma_enabled(dma_en));

  // Free-running 125 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Levels are looked at mid-cycle, where they have settled.
  task automatic wait_lvl(ref logic s, input logic v, input string n);
    for (int i = 0; i < 400; i++) begin
      @(negedge sys_clk);
      if (s === v) return;
    end
    fail_count++;
    $display("[ERR] %s timed out", n);
    stop_test();
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    hpdic_host_i.xfer(1'b0, a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e,
    input string n);
    logic [7:0] q;
    hpdic_host_i.xfer(1'b0, a, 1'b0, 8'h00, q);
    `CHK(n, e, q)
  endtask

  task automatic ctl(input logic [1:0] m, input logic tx, rx, init);
    wr(3'h0, {init, m, 3'h0, tx, rx});
  endtask

  task automatic dma(input logic w, input logic [7:0] d,
    output logic [7:0] q);
    wait_lvl(req_n, 1'b0, "request");
    hpdic_host_i.xfer(1'b1, 3'h0, w, d, q);
  endtask

  // The core word is held offered until the port takes it.
  task automatic push(input logic [23:0] w);
    @(posedge sys_clk);
    tx_data <= w;
    tx_valid <= 1'b1;
    wait_lvl(tx_ready, 1'b1, "tx ready");
    @(posedge sys_clk);
    tx_valid <= 1'b0;
  endtask

  task automatic pop(input logic [23:0] e, m);
    wait_lvl(rx_valid, 1'b1, "rx valid");
    `CHK("rx word", e & m, rx_data & m)
    `CHK("rx full", 1'b1, rxf)
    @(posedge sys_clk);
    rx_ready <= 1'b1;
    @(posedge sys_clk);
    rx_ready <= 1'b0;
  endtask

  task automatic t_reset();
    rd(3'h0, 8'h00, "control");
    rd(3'h1, 8'h17, "vector");
    `CHK("vec addr", 7'h2e, vaddr)
    `CHK("request", 1'b1, req_n)
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      ctl(2'(m), 1'b0, 1'b0, 1'b1);
      `CHK("dma on", m != 0, dma_en)
      rd(3'h0, {1'b0, 2'(m), 5'h00}, "init");
    end
  endtask

  // The far side stalls until the buffer and the byte registers are full.
  task automatic t_fill();
    logic [7:0] q;
    ctl(2'h3, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 33; i++) dma(1'b1, 8'(i + 1), q);
    `CHK("refused", 1'b1, req_n)
    for (int i = 0; i < 33; i++) pop(24'(i + 1), 24'hff);
  endtask

  task automatic t_dma24();
    logic [7:0] q;
    logic [7:0] b [6] = '{8'haa, 8'hbb, 8'hcc, 8'h11, 8'h22, 8'h33};
    ctl(2'h1, 1'b1, 1'b0, 1'b1);
    dma(1'b1, 8'h77, q);
    ctl(2'h1, 1'b1, 1'b0, 1'b1);
    foreach (b[i]) dma(1'b1, b[i], q);
    pop(24'haabbcc, 24'hffffff);
    pop(24'h112233, 24'hffffff);
    ctl(2'h2, 1'b1, 1'b0, 1'b0);
    foreach (b[i]) if (i < 3) dma(1'b1, 8'h44 + 8'(i * 17), q);
    pop(24'h445566, 24'hffffff);
    dma(1'b1, 8'h01, q);
    dma(1'b1, 8'h02, q);
    pop(24'h000102, 24'h00ffff);
  endtask

  task automatic t_rx();
    logic [7:0] q;
    ctl(2'h3, 1'b0, 1'b1, 1'b1);
    `CHK("core empty", 1'b1, txe)
    push(24'h123456);
    dma(1'b0, 8'h00, q);
    `CHK("dma byte", 8'h56, q)
    ctl(2'h0, 1'b0, 1'b1, 1'b1);
    push(24'hc0ffee);
    wait_lvl(req_n, 1'b0, "irq request");
    hpdic_host_i.xfer(1'b1, 3'h0, 1'b0, 8'h00, q);
    `CHK("irq vector", 8'h0f, q)
    rd(3'h5, 8'hc0, "rx high");
    rd(3'h6, 8'hff, "rx mid");
    rd(3'h7, 8'hee, "rx low");
    `CHK("request off", 1'b1, req_n)
  endtask

  task automatic t_cmd();
    ctl(2'h2, 1'b1, 1'b0, 1'b1);
    wr(3'h1, 8'haa);
    `CHK("cmd pending", 1'b1, pending)
    `CHK("cmd addr", 7'h54, vaddr)
    @(posedge sys_clk);
    cmd_ack <= 1'b1;
    @(posedge sys_clk);
    cmd_ack <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK("cmd taken", 1'b0, pending)
    rd(3'h1, 8'h2a, "vector");
    wr(3'h1, 8'h85);
    wr(3'h1, 8'h05);
    `CHK("cmd cancel", 1'b0, pending)
  endtask

  task automatic t_resets();
    for (int k = 0; k < 3; k++) begin
      ctl(2'h1, 1'b1, 1'b0, 1'b0);
      wr(3'h1, 8'h09);
      @(posedge sys_clk);
      {stop_mode, indiv_reset, soft_reset} <= 3'(1 << k);
      @(posedge sys_clk);
      {stop_mode, indiv_reset, soft_reset} <= 3'h0;
      repeat (2) @(posedge sys_clk);
      `CHK("mode clear", 1'b0, dma_en)
      `CHK("vec reload", 7'h2e, vaddr)
      rd(3'h0, 8'h00, "control");
    end
  endtask

  // Reset for five cycles, then the scenarios in turn.
  initial begin
    rst = 1'b1;
    {soft_reset, indiv_reset, stop_mode, tx_valid, rx_ready} = 5'h0;
    {cmd_ack, tx_data} = 25'h0;
    fail_count = 0;
    tests_run = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_fill();
    t_dma24();
    t_rx();
    t_cmd();
    t_resets();
    stop_test();
  end
endmodule // tb_top
